// ===== src/pci_serial_gps_carrier.v
// PCI I/O target with a serial register set, interrupt steering and channel routing.
`include "carrier_defs.vh"
`default_nettype none

module pci_serial_gps_carrier #(
    parameter RX_DEPTH = 16,
    parameter RX_ADDR_W = 4
) (
    input wire CLK,
    input wire ARST_N,
    input wire CFG_WR,
    input wire [7:0] CFG_ADDR,
    input wire [31:0] CFG_WDATA,
    input wire [31:0] IO_ADDR,
    input wire IO_RD,
    input wire IO_WR,
    input wire [7:0] IO_WDATA,
    output reg [7:0] IO_RDATA,
    output reg IO_CLAIM,
    output reg INTA_N,
    input wire IRQ_SOURCE_JUMPER,
    input wire BYPASS_MODE,
    input wire SECOND_TIMING_PULSE,
    input wire PRIMARY_RECEIVER_CHANNEL_RX,
    output reg PRIMARY_RECEIVER_CHANNEL_TX,
    input wire SECONDARY_RECEIVER_CHANNEL_RX,
    output reg SECONDARY_RECEIVER_CHANNEL_TX,
    input wire PRIMARY_CHANNEL_CONNECTOR_RX,
    output reg PRIMARY_CHANNEL_CONNECTOR_TX,
    output reg PRIMARY_CHANNEL_CONNECTOR_PPS,
    input wire SECONDARY_CHANNEL_CONNECTOR_RX,
    output reg SECONDARY_CHANNEL_CONNECTOR_TX,
    output reg SECONDARY_CHANNEL_CONNECTOR_PPS
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    reg [31:0] io_base_reg;
    reg [7:0] irq_enable_reg;
    reg [7:0] line_control_reg;
    reg [7:0] handshake_control_reg;
    reg [7:0] scratch_byte_reg;
    reg [15:0] divisor_reg;
    reg queue_enable_reg;
    reg [1:0] trigger_reg;
    reg [7:0] transmit_holding_reg;
    reg thr_full_reg;
    reg thre_pend_reg;
    reg overrun_reg;
    reg frame_err_reg;
    reg parity_err_reg;
    reg break_reg;
    reg [3:0] msr_delta_reg;
    reg pps_prev_reg;
    reg [15:0] baud_count_reg;
    reg tick16_reg;

    wire hit;
    wire [2:0] ofs;
    wire rd;
    wire wr;
    wire dlab;
    wire rx_fifo_clear;
    wire [7:0] rx_head;
    wire rx_head_valid;
    wire rx_fifo_ready;
    wire [RX_ADDR_W:0] rx_level;
    wire rx_pop;
    wire [7:0] rx_byte;
    wire rx_byte_valid;
    wire rx_byte_ferr;
    wire tx_busy;
    wire tx_line;
    wire tx_start;
    wire uart_rx_line;
    wire [7:0] lsr_value;
    wire [7:0] msr_value;
    wire [3:0] modem_lines;
    reg [3:0] iir_code;
    reg [RX_ADDR_W:0] trigger_level;
    wire ls_int;
    wire rd_int;
    wire th_int;
    wire ms_int;
    wire uart_irq;
    wire iir_read;
    wire pps_edge;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode: the low three address bits select the register.

    assign hit = (IO_ADDR[31:`IO_WINDOW_BITS] == io_base_reg[31:`IO_WINDOW_BITS]);
    assign ofs = IO_ADDR[`IO_WINDOW_BITS-1:0];
    assign rd = IO_RD && hit;
    assign wr = IO_WR && hit;
    assign dlab = line_control_reg[`LCR_DIVISOR_ACCESS];
    assign iir_read = rd && (ofs == `OFS_IRQ_IDENT);
    assign rx_pop = rd && (ofs == `OFS_DATA) && !dlab;
    assign rx_fifo_clear = wr && (ofs == `OFS_IRQ_IDENT) && IO_WDATA[`FCR_RX_CLEAR];

    // Modem lines: outside loopback, DCD follows the second pulse so timing software can watch it.
    assign modem_lines = handshake_control_reg[`MCR_LOOPBACK] ?
        {handshake_control_reg[3], handshake_control_reg[2],
         handshake_control_reg[0], handshake_control_reg[1]} :
        {SECOND_TIMING_PULSE, 1'b0, 1'b1, 1'b1};
    assign pps_edge = (modem_lines[3] != pps_prev_reg);
    assign msr_value = {modem_lines, msr_delta_reg};
    assign lsr_value = {1'b0, !thr_full_reg && !tx_busy, !thr_full_reg, break_reg,
                        frame_err_reg, parity_err_reg, overrun_reg, rx_head_valid};

    always @*
    begin
        case (trigger_reg)
            2'h0: trigger_level = 5'h01;
            2'h1: trigger_level = 5'h04;
            2'h2: trigger_level = 5'h08;
            2'h3: trigger_level = 5'h0E;
            default: trigger_level = 5'h01;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt identification, highest priority first.

    assign ls_int = irq_enable_reg[`IER_LINE_STATE] &&
                    (overrun_reg || frame_err_reg || parity_err_reg || break_reg);
    assign rd_int = irq_enable_reg[`IER_RX_DATA] &&
                    (queue_enable_reg ? (rx_level >= trigger_level) : rx_head_valid);
    assign th_int = irq_enable_reg[`IER_TX_EMPTY] && thre_pend_reg;
    assign ms_int = irq_enable_reg[`IER_HANDSHAKE] && (msr_delta_reg != 4'h0);
    assign uart_irq = (ls_int || rd_int || th_int || ms_int) &&
                      handshake_control_reg[`MCR_OUT2];

    always @*
    begin
        if (ls_int)
            iir_code = `IIR_LINE_STATE;
        else if (rd_int)
            iir_code = `IIR_RX_DATA;
        else if (th_int)
            iir_code = `IIR_TX_EMPTY;
        else if (ms_int)
            iir_code = `IIR_HANDSHAKE;
        else
            iir_code = `IIR_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration base and register writes.

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            io_base_reg <= `IO_SPACE_FLAG;
            irq_enable_reg <= `IRQ_ENABLE_RESET;
            line_control_reg <= `LINE_CONTROL_RESET;
            handshake_control_reg <= `HANDSHAKE_CONTROL_RESET;
            scratch_byte_reg <= `SCRATCH_RESET;
            divisor_reg <= `DIVISOR_RESET;
            queue_enable_reg <= `QUEUE_ENABLE_RESET;
            trigger_reg <= `TRIGGER_RESET;
            transmit_holding_reg <= 8'h00;
        end
        else
        begin
            if (CFG_WR && (CFG_ADDR == `CFG_IO_BASE_ADDR))
                io_base_reg <= {CFG_WDATA[31:`IO_WINDOW_BITS], 3'h1};
            if (wr)
            begin
                case (ofs)
                    `OFS_DATA:
                    begin
                        if (dlab)
                            divisor_reg[7:0] <= IO_WDATA;
                        else
                            transmit_holding_reg <= IO_WDATA;
                    end
                    `OFS_IRQ_ENABLE:
                    begin
                        if (dlab)
                            divisor_reg[15:8] <= IO_WDATA;
                        else
                            irq_enable_reg <= {4'h0, IO_WDATA[3:0]};
                    end
                    `OFS_IRQ_IDENT:
                    begin
                        queue_enable_reg <= IO_WDATA[`FCR_ENABLE];
                        trigger_reg <= IO_WDATA[7:6];
                    end
                    `OFS_LINE_CONTROL: line_control_reg <= IO_WDATA;
                    `OFS_HANDSHAKE_CONTROL: handshake_control_reg <= {3'h0, IO_WDATA[4:0]};
                    `OFS_SCRATCH: scratch_byte_reg <= IO_WDATA;
                    default: scratch_byte_reg <= scratch_byte_reg;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: an event in the clearing cycle always wins.

    assign tx_start = thr_full_reg && !tx_busy;

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            thr_full_reg <= 1'b0;
            thre_pend_reg <= 1'b0;
            overrun_reg <= 1'b0;
            frame_err_reg <= 1'b0;
            parity_err_reg <= 1'b0;
            break_reg <= 1'b0;
            msr_delta_reg <= 4'h0;
            pps_prev_reg <= 1'b0;
        end
        else
        begin
            pps_prev_reg <= modem_lines[3];
            if (wr && (ofs == `OFS_DATA) && !dlab)
                thr_full_reg <= 1'b1;
            else if (tx_start)
                thr_full_reg <= 1'b0;

            if (tx_start ||
                (wr && (ofs == `OFS_IRQ_ENABLE) && !dlab && IO_WDATA[`IER_TX_EMPTY] &&
                 !irq_enable_reg[`IER_TX_EMPTY] && !thr_full_reg))
                thre_pend_reg <= 1'b1;
            else if ((wr && (ofs == `OFS_DATA) && !dlab) ||
                     (iir_read && (iir_code == `IIR_TX_EMPTY)))
                thre_pend_reg <= 1'b0;

            if (rx_byte_valid && !rx_fifo_ready)
                overrun_reg <= 1'b1;
            else if (rd && (ofs == `OFS_LINE_STATE))
                overrun_reg <= 1'b0;
            else if (wr && (ofs == `OFS_LINE_STATE))
                overrun_reg <= IO_WDATA[1];

            if (rx_byte_valid && rx_byte_ferr)
                frame_err_reg <= 1'b1;
            else if (rd && (ofs == `OFS_LINE_STATE))
                frame_err_reg <= 1'b0;
            else if (wr && (ofs == `OFS_LINE_STATE))
                frame_err_reg <= IO_WDATA[3];

            if (rd && (ofs == `OFS_LINE_STATE))
            begin
                parity_err_reg <= 1'b0;
                break_reg <= 1'b0;
            end
            else if (wr && (ofs == `OFS_LINE_STATE))
            begin
                parity_err_reg <= IO_WDATA[2];
                break_reg <= IO_WDATA[4];
            end

            if (pps_edge)
                msr_delta_reg <= msr_delta_reg | 4'h8;
            else if (rd && (ofs == `OFS_HANDSHAKE_STATE))
                msr_delta_reg <= 4'h0;
            else if (wr && (ofs == `OFS_HANDSHAKE_STATE))
                msr_delta_reg <= IO_WDATA[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, claim and pins, all registered.

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            IO_RDATA <= 8'h00;
            IO_CLAIM <= 1'b0;
            INTA_N <= 1'b1;
            PRIMARY_RECEIVER_CHANNEL_TX <= 1'b1;
            SECONDARY_RECEIVER_CHANNEL_TX <= 1'b1;
            PRIMARY_CHANNEL_CONNECTOR_TX <= 1'b1;
            SECONDARY_CHANNEL_CONNECTOR_TX <= 1'b1;
            PRIMARY_CHANNEL_CONNECTOR_PPS <= 1'b0;
            SECONDARY_CHANNEL_CONNECTOR_PPS <= 1'b0;
        end
        else
        begin
            IO_CLAIM <= rd || wr;
            if (rd)
            begin
                case (ofs)
                    `OFS_DATA: IO_RDATA <= dlab ? divisor_reg[7:0] : rx_head;
                    `OFS_IRQ_ENABLE: IO_RDATA <= dlab ? divisor_reg[15:8] : irq_enable_reg;
                    `OFS_IRQ_IDENT: IO_RDATA <= {queue_enable_reg ? `IIR_QUEUE_FLAGS : 2'h0,
                                                 2'h0, iir_code};
                    `OFS_LINE_CONTROL: IO_RDATA <= line_control_reg;
                    `OFS_HANDSHAKE_CONTROL: IO_RDATA <= handshake_control_reg;
                    `OFS_LINE_STATE: IO_RDATA <= lsr_value;
                    `OFS_HANDSHAKE_STATE: IO_RDATA <= msr_value;
                    `OFS_SCRATCH: IO_RDATA <= scratch_byte_reg;
                    default: IO_RDATA <= 8'h00;
                endcase
            end
            // Level-sensitive: held low for as long as the chosen source asserts.
            INTA_N <= !(IRQ_SOURCE_JUMPER ? SECOND_TIMING_PULSE : uart_irq);
            PRIMARY_RECEIVER_CHANNEL_TX <= BYPASS_MODE ?
                PRIMARY_CHANNEL_CONNECTOR_RX : tx_line;
            PRIMARY_CHANNEL_CONNECTOR_TX <= BYPASS_MODE ?
                PRIMARY_RECEIVER_CHANNEL_RX : 1'b1;
            SECONDARY_RECEIVER_CHANNEL_TX <= SECONDARY_CHANNEL_CONNECTOR_RX;
            SECONDARY_CHANNEL_CONNECTOR_TX <= SECONDARY_RECEIVER_CHANNEL_RX;
            PRIMARY_CHANNEL_CONNECTOR_PPS <= SECOND_TIMING_PULSE;
            SECONDARY_CHANNEL_CONNECTOR_PPS <= SECOND_TIMING_PULSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud divider: one tick16 pulse every divisor cycles.

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            baud_count_reg <= 16'h0000;
            tick16_reg <= 1'b0;
        end
        else if (baud_count_reg <= 16'h0001)
        begin
            baud_count_reg <= divisor_reg;
            tick16_reg <= 1'b1;
        end
        else
        begin
            baud_count_reg <= baud_count_reg - 16'h0001;
            tick16_reg <= 1'b0;
        end
    end

    // The serial controller is cut off from the receiver while bypassed.
    assign uart_rx_line = handshake_control_reg[`MCR_LOOPBACK] ? tx_line :
                          (BYPASS_MODE ? 1'b1 : PRIMARY_RECEIVER_CHANNEL_RX);

    serial_shifter shifter (
        .clk(CLK),
        .arst_n(ARST_N),
        .tick16(tick16_reg),
        .tx_data(transmit_holding_reg),
        .tx_start(tx_start),
        .tx_busy(tx_busy),
        .tx_line(tx_line),
        .rx_line(uart_rx_line),
        .rx_data(rx_byte),
        .rx_valid(rx_byte_valid),
        .rx_frame_err(rx_byte_ferr)
    );

    // Serial input cannot be stalled, so a full queue shows as overrun.
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH),
        .ADDR_W(RX_ADDR_W)
    ) rx_queue (
        .clk(CLK),
        .arst_n(ARST_N),
        .clear(rx_fifo_clear),
        .in_valid(rx_byte_valid),
        .in_data(rx_byte),
        .in_ready(rx_fifo_ready),
        .out_valid(rx_head_valid),
        .out_data(rx_head),
        .out_ready(rx_pop),
        .level(rx_level)
    );

endmodule

`default_nettype wire

// ===== src/carrier_defs.vh
// Constants of the PCI serial carrier for a GPS receiver module.
`ifndef CARRIER_DEFS_VH
`define CARRIER_DEFS_VH

`define CFG_IO_BASE_ADDR 8'h1C
`define IO_WINDOW_BITS 3
`define IO_SPACE_FLAG 32'h00000001

`define OFS_DATA 3'h0
`define OFS_IRQ_ENABLE 3'h1
`define OFS_IRQ_IDENT 3'h2
`define OFS_LINE_CONTROL 3'h3
`define OFS_HANDSHAKE_CONTROL 3'h4
`define OFS_LINE_STATE 3'h5
`define OFS_HANDSHAKE_STATE 3'h6
`define OFS_SCRATCH 3'h7

`define IRQ_ENABLE_RESET 8'h00
`define LINE_CONTROL_RESET 8'h00
`define HANDSHAKE_CONTROL_RESET 8'h00
`define SCRATCH_RESET 8'h00
`define DIVISOR_RESET 16'h0001
`define QUEUE_ENABLE_RESET 1'b0
`define TRIGGER_RESET 2'h0

`define LCR_DIVISOR_ACCESS 7
`define MCR_OUT2 3
`define MCR_LOOPBACK 4
`define IER_RX_DATA 0
`define IER_TX_EMPTY 1
`define IER_LINE_STATE 2
`define IER_HANDSHAKE 3
`define FCR_ENABLE 0
`define FCR_RX_CLEAR 1

`define IIR_NONE 4'h1
`define IIR_LINE_STATE 4'h6
`define IIR_RX_DATA 4'h4
`define IIR_TX_EMPTY 4'h2
`define IIR_HANDSHAKE 4'h0
`define IIR_QUEUE_FLAGS 2'h3

`define OVERSAMPLE 5'h10
`define HALF_OVERSAMPLE 5'h08
`define FRAME_BITS 4'hA
`define RX_DATA_BITS 4'h9

`endif

// ===== src/byte_fifo.v
// Flip-flop FIFO with valid/ready on both sides and a fill level.
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter ADDR_W = 4
) (
    input wire clk,
    input wire arst_n,
    input wire clear,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready,
    output wire [ADDR_W:0] level
);

    reg [WIDTH-1:0] store_reg [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr_reg;
    reg [ADDR_W-1:0] rd_ptr_reg;
    reg [ADDR_W:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != DEPTH[ADDR_W:0]);
    assign out_valid = (count_reg != {(ADDR_W+1){1'b0}});
    assign out_data = store_reg[rd_ptr_reg];
    assign level = count_reg;
    assign push = in_valid && in_ready && !clear;
    assign pop = out_valid && out_ready && !clear;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : entry
            always @(posedge clk)
            begin
                if (push && (wr_ptr_reg == i[ADDR_W-1:0]))
                    store_reg[i] <= in_data;
            end
        end
    endgenerate

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_reg <= {ADDR_W{1'b0}};
            rd_ptr_reg <= {ADDR_W{1'b0}};
            count_reg <= {(ADDR_W+1){1'b0}};
        end
        else if (clear)
        begin
            wr_ptr_reg <= {ADDR_W{1'b0}};
            rd_ptr_reg <= {ADDR_W{1'b0}};
            count_reg <= {(ADDR_W+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
            if (push && !pop)
                count_reg <= count_reg + {{ADDR_W{1'b0}}, 1'b1};
            else if (pop && !push)
                count_reg <= count_reg - {{ADDR_W{1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// ===== src/serial_shifter.v
// Serial transmitter and receiver, 8 data bits, one stop bit, 16x oversampling.
`include "carrier_defs.vh"
`default_nettype none

module serial_shifter (
    input wire clk,
    input wire arst_n,
    input wire tick16,
    input wire [7:0] tx_data,
    input wire tx_start,
    output wire tx_busy,
    output wire tx_line,
    input wire rx_line,
    output reg [7:0] rx_data,
    output reg rx_valid,
    output reg rx_frame_err
);

    reg [9:0] tx_shift_reg;
    reg [3:0] tx_bits_reg;
    reg [4:0] tx_phase_reg;
    reg rx_active_reg;
    reg [3:0] rx_bits_reg;
    reg [4:0] rx_phase_reg;
    reg [8:0] rx_shift_reg;

    assign tx_busy = (tx_bits_reg != 4'h0);
    assign tx_line = tx_shift_reg[0];

    // Transmit: start bit, eight data bits LSB first, stop bit.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_shift_reg <= 10'h3FF;
            tx_bits_reg <= 4'h0;
            tx_phase_reg <= 5'h00;
        end
        else if (!tx_busy)
        begin
            if (tx_start)
            begin
                tx_shift_reg <= {1'b1, tx_data, 1'b0};
                tx_bits_reg <= `FRAME_BITS;
                tx_phase_reg <= 5'h00;
            end
        end
        else if (tick16)
        begin
            if (tx_phase_reg == `OVERSAMPLE - 5'h01)
            begin
                tx_phase_reg <= 5'h00;
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                tx_bits_reg <= tx_bits_reg - 4'h1;
            end
            else
                tx_phase_reg <= tx_phase_reg + 5'h01;
        end
    end

    // Receive: the start edge is checked at mid-bit so a glitch does not frame.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_active_reg <= 1'b0;
            rx_bits_reg <= 4'h0;
            rx_phase_reg <= 5'h00;
            rx_shift_reg <= 9'h000;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_frame_err <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (tick16)
            begin
                if (!rx_active_reg)
                begin
                    if (!rx_line)
                    begin
                        if (rx_phase_reg == `HALF_OVERSAMPLE - 5'h01)
                        begin
                            rx_active_reg <= 1'b1;
                            rx_phase_reg <= 5'h00;
                            rx_bits_reg <= 4'h0;
                        end
                        else
                            rx_phase_reg <= rx_phase_reg + 5'h01;
                    end
                    else
                        rx_phase_reg <= 5'h00;
                end
                else if (rx_phase_reg == `OVERSAMPLE - 5'h01)
                begin
                    rx_phase_reg <= 5'h00;
                    rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
                    rx_bits_reg <= rx_bits_reg + 4'h1;
                    if (rx_bits_reg == `RX_DATA_BITS - 4'h1)
                    begin
                        rx_active_reg <= 1'b0;
                        rx_data <= rx_shift_reg[8:1];
                        rx_frame_err <= !rx_line;
                        rx_valid <= 1'b1;
                    end
                end
                else
                    rx_phase_reg <= rx_phase_reg + 5'h01;
            end
        end
    end

endmodule

`default_nettype wire

// ===== src/dummy_unused.v
`default_nettype none
`default_nettype wire

// ===== test/carrier_props.sv
// Port-level assertions for the PCI serial carrier.
`default_nettype none
module carrier_props (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CFG_WR,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [7:0] IO_WDATA,
    input wire logic [7:0] IO_RDATA,
    input wire logic IO_CLAIM,
    input wire logic INTA_N,
    input wire logic IRQ_SOURCE_JUMPER,
    input wire logic BYPASS_MODE,
    input wire logic SECOND_TIMING_PULSE,
    input wire logic PRIMARY_RECEIVER_CHANNEL_RX,
    input wire logic PRIMARY_RECEIVER_CHANNEL_TX,
    input wire logic SECONDARY_RECEIVER_CHANNEL_RX,
    input wire logic PRIMARY_CHANNEL_CONNECTOR_RX,
    input wire logic PRIMARY_CHANNEL_CONNECTOR_TX,
    input wire logic SECONDARY_CHANNEL_CONNECTOR_TX
);
    logic [28:0] base_reg;
    logic hit;
    // A shadow of the window base, so decoding is judged independently.
    always @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            base_reg <= 29'h0;
        else if (CFG_WR && CFG_ADDR == 8'h1C)
            base_reg <= CFG_WDATA[31:3];
    assign hit = IO_ADDR[31:3] == base_reg;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////////////////////////////
    sequence s_scr_wr;
        IO_WR && !IO_RD && hit && IO_ADDR[2:0] == 3'h7;
    endsequence
    sequence s_scr_rd;
        IO_RD && !IO_WR && hit && IO_ADDR[2:0] == 3'h7;
    endsequence
    AST_HIT_CLAIM: assert property ((IO_RD || IO_WR) && hit |=> IO_CLAIM)
        else $error("hit access not claimed");
    AST_MISS_QUIET: assert property ((IO_RD || IO_WR) && !hit |=> !IO_CLAIM)
        else $error("miss access claimed");
    AST_SCRATCH: assert property (s_scr_wr ##1 !IO_WR ##1 s_scr_rd
        |=> IO_RDATA == $past(IO_WDATA, 3)) else $error("scratch readback wrong");
    AST_PULSE_IRQ: assert property (IRQ_SOURCE_JUMPER
        |=> INTA_N == !$past(SECOND_TIMING_PULSE)) else $error("pulse irq wrong");
    AST_BYPASS_TX: assert property (BYPASS_MODE
        |=> PRIMARY_RECEIVER_CHANNEL_TX == $past(PRIMARY_CHANNEL_CONNECTOR_RX))
        else $error("bypass to receiver wrong");
    AST_BYPASS_CONN: assert property (BYPASS_MODE
        |=> PRIMARY_CHANNEL_CONNECTOR_TX == $past(PRIMARY_RECEIVER_CHANNEL_RX))
        else $error("bypass to connector wrong");
    AST_CONN_IDLE: assert property (!BYPASS_MODE |=> PRIMARY_CHANNEL_CONNECTOR_TX)
        else $error("connector active outside bypass");
    AST_SECONDARY: assert property (1'b1
        |=> SECONDARY_CHANNEL_CONNECTOR_TX == $past(SECONDARY_RECEIVER_CHANNEL_RX))
        else $error("secondary channel not routed");
endmodule
bind pci_serial_gps_carrier carrier_props u_props (.*);
`default_nettype wire

// ===== test/gps_receiver_model.sv
// Behavioural receiver module: serial frames and a timing pulse on command.
`default_nettype none
module gps_receiver_model (
    input wire logic clk,
    output logic rx_line,
    output logic pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rx_line = 1'b1;
        pulse = 1'b0;
    end
    // Sixteen clocks per bit, matching a divisor of one.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            rx_line <= f[i];
            repeat (15) @(posedge clk);
        end
    endtask
    task automatic pps(input logic v);
        @(posedge clk);
        pulse <= v;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the PCI serial carrier.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] io_addr = 32'h0;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic jmp = 1'b0, byp = 1'b0, con_rx = 1'b1, scon_rx = 1'b1, srx = 1'b1;
    wire [7:0] io_rdata;
    wire io_claim, inta_n, ptx, stx, ctx, cpps, sctx, prx, pps;
    int error_cnt = 0, compares = 0, cyc = 0, i;
    logic [7:0] q;
    logic [18:0] rows [0:5] = '{{3'h1, 8'h0F, 8'h0F}, {3'h1, 8'hFF, 8'h0F},
        {3'h3, 8'h1B, 8'h1B}, {3'h7, 8'h5A, 8'h5A}, {3'h4, 8'h0B, 8'h0B},
        {3'h4, 8'h08, 8'h08}};
    pci_serial_gps_carrier u_dut (.CLK(clk), .ARST_N(arst_n), .CFG_WR(cfg_wr),
        .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .IO_ADDR(io_addr), .IO_RD(io_rd),
        .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_CLAIM(io_claim),
        .INTA_N(inta_n), .IRQ_SOURCE_JUMPER(jmp), .BYPASS_MODE(byp),
        .SECOND_TIMING_PULSE(pps), .PRIMARY_RECEIVER_CHANNEL_RX(prx),
        .PRIMARY_RECEIVER_CHANNEL_TX(ptx), .SECONDARY_RECEIVER_CHANNEL_RX(srx),
        .SECONDARY_RECEIVER_CHANNEL_TX(stx), .PRIMARY_CHANNEL_CONNECTOR_RX(con_rx),
        .PRIMARY_CHANNEL_CONNECTOR_TX(ctx), .PRIMARY_CHANNEL_CONNECTOR_PPS(cpps),
        .SECONDARY_CHANNEL_CONNECTOR_RX(scon_rx), .SECONDARY_CHANNEL_CONNECTOR_TX(sctx),
        .SECONDARY_CHANNEL_CONNECTOR_PPS());
    gps_receiver_model u_gps (.clk(clk), .rx_line(prx), .pulse(pps));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One strobe cycle; the answer is taken once the claim edge has landed.
    task automatic io(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wr <= w;
        io_rd <= !w;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1 q = io_rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        io(0, 32'h2, 8'h00);
        chk(q, 8'h01);
        io(0, 32'h7, 8'h00);
        chk(q, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            io(1, {29'h0, rows[i][18:16]}, rows[i][15:8]);
            chk(io_claim, 1'b1);
            io(0, {29'h0, rows[i][18:16]}, 8'h00);
            chk(q, rows[i][7:0]);
        end
        $display("register table done");
        io(1, 32'h1, 8'h02);
        settle(3);
        chk(inta_n, 1'b0);
        io(0, 32'h2, 8'h00);
        chk(q, 8'h02);
        io(1, 32'h1, 8'h00);
        settle(3);
        chk(inta_n, 1'b1);
        jmp <= 1'b1;
        u_gps.pps(1'b1);
        settle(2);
        chk(inta_n, 1'b0);
        chk(cpps, 1'b1);
        u_gps.pps(1'b0);
        settle(2);
        chk(inta_n, 1'b1);
        $display("interrupt steering done");
        u_gps.send(8'hA5);
        settle(20);
        io(0, 32'h5, 8'h00);
        chk(q[0], 1'b1);
        io(0, 32'h0, 8'h00);
        chk(q, 8'hA5);
        io(1, 32'h0, 8'h55);
        settle(6);
        chk(ptx, 1'b0);
        $display("serial path done");
        byp <= 1'b1;
        scon_rx <= 1'b0;
        srx <= 1'b0;
        settle(3);
        chk(ptx, 1'b1);
        chk(ctx, 1'b1);
        chk(sctx, 1'b0);
        chk(stx, 1'b0);
        $display("routing done");
        cfg_wr <= 1'b1;
        cfg_addr <= 8'h1C;
        cfg_wdata <= 32'h305;
        @(posedge clk);
        cfg_addr <= 8'h10;
        cfg_wdata <= 32'h500;
        @(posedge clk);
        cfg_wr <= 1'b0;
        io(1, 32'h307, 8'h3C);
        chk(io_claim, 1'b1);
        io(0, 32'h7, 8'h00);
        chk(io_claim, 1'b0);
        io(0, 32'h307, 8'h00);
        chk(q, 8'h3C);
        io(0, 32'h308, 8'h00);
        chk(io_claim, 1'b0);
        $display("window decode done");
        report_and_stop();
    end
endmodule
`default_nettype wire
